/* File: design/ict_set_match.sv */
`default_nettype none
module ict_set_match #(
   parameter int WAYS = 64,
   parameter int TAGW = 32,
   parameter int WAYW = 6
) (
   input wire logic [WAYS-1:0][TAGW-1:0] set_tags, // tags of the chosen set
   input wire logic [WAYS-1:0] set_valid, // valid bits of the chosen set
   input wire logic [TAGW-1:0] look_tag, // tag to look up
   output logic [WAYS-1:0] hit_vec, // one bit per matching way
   output logic hit, // any way matched
   output logic [WAYW-1:0] hit_way // lowest matching way
);
   import ict_pkg::*;
   // every way of the set is compared in parallel
   always_comb begin
      hit_vec = '0;
      hit_way = '0;
      for (int w = 0; w < WAYS; w++) begin
         hit_vec[w] = set_valid[w] && (set_tags[w] == look_tag);
      end
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (hit_vec[w]) begin
            hit_way = WAYW'(w);
         end
      end
      hit = |hit_vec;
   end
endmodule
`default_nettype wire

/* File: design/ict_tag_lookup.sv */
// Implementation choices: the APB interface to the registers and the address map.
`include "ict_regs.svh"
`default_nettype none
// Summary of operation
// - virtual address is ea, pid, space bit
// - offset bits 27:31, set index 23:26
// - tag holds ea 0:22, pid, space
// - compare tag against every way of set
// - management ops use data space bit
// - index by real bits, tag by virtual
// - synonym duplicates allowed, never detected
// - bits 22:31 identical in ea, real
// - no allocate: no execute or inhibited
// - block invalidate removes matching line only
// - flash invalidate all, privileged only
// - cache read copies tag, data; privileged
// - block touch starts fill of block
// - block operations act on one line
// - config register steers prefetch and touch
// - line holds 32 bytes, four doublewords
module ict_tag_lookup #(
   parameter int WAYS = 64,
   parameter int PIDW = 8
) (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped offset
   input wire logic [PIDW-1:0] process_identifier, // machine state pid
   input wire logic instr_addr_space_bit, // machine state fetch space
   input wire logic data_addr_space_bit, // machine state data space
   input wire logic priv_state, // machine state privileged
   input wire logic fetch_req, // fetch lookup request
   input wire logic [31:0] fetch_effective_addr, // fetch effective address
   input wire logic [31:0] fetch_real_addr, // fetch translated address
   input wire logic fetch_exec_ok, // page has execute permission
   input wire logic fetch_cache_inhib, // page caching inhibited
   output logic fetch_hit, // lookup hit, one cycle
   output logic fetch_miss, // lookup miss, one cycle
   output logic [`ICT_IDX_HI-`ICT_IDX_LO:0] fetch_set, // set of the hit
   output logic [$clog2(WAYS)-1:0] fetch_way, // way of the hit
   input wire logic op_req, // management op request
   input wire ict_pkg::ict_op_t op_code, // management op kind
   input wire logic [31:0] op_effective_addr, // op effective address
   input wire logic [31:0] op_real_addr, // op translated address
   input wire logic [$clog2(WAYS)-1:0] op_way, // way for cache read
   input wire logic op_exec_ok, // touch page executable
   input wire logic op_cache_inhib, // touch page inhibited
   output logic op_ready, // op can be taken
   output logic op_done, // op finished, one cycle
   output logic op_refused, // op refused, one cycle
   input wire logic pipe_stall, // instruction pipeline stalled
   output logic fill_req, // line fill start, one cycle
   output logic [31:0] fill_real_addr, // line-aligned fill address
   input wire logic fill_done, // fill data all received
   output logic [1:0] prefetch_lines, // extra lines to prefetch
   output logic arr_rd_req, // data array read strobe
   output logic [`ICT_IDX_HI-`ICT_IDX_LO:0] arr_rd_set, // data array read set
   output logic [$clog2(WAYS)-1:0] arr_rd_way, // data array read way
   input wire logic [31:0] arr_rd_data // data array word, same cycle
);
   import ict_pkg::*;

   localparam int WAYW = $clog2(WAYS);
   localparam int IDXW = `ICT_IDX_HI - `ICT_IDX_LO + 1;
   localparam int SETS = 1 << IDXW;
   localparam int EATW = `ICT_TAG_HI - `ICT_TAG_LO + 1;
   localparam int TAGW = EATW + PIDW + 1;

   typedef struct packed {
      ict_state_t st;
      logic [SETS-1:0][WAYS-1:0][TAGW-1:0] tag;
      logic [SETS-1:0][WAYS-1:0] vld;
      logic [WAYW-1:0] rr;
      logic [TAGW-1:0] f_tag;
      logic [IDXW-1:0] f_set;
      logic f_alloc, f_touch;
      logic fill_req;
      logic [31:0] fill_ra;
      logic fetch_hit, fetch_miss;
      logic [IDXW-1:0] fetch_set;
      logic [WAYW-1:0] fetch_way;
      logic op_ready, op_done, op_refused;
      logic arr_rd_req;
      logic [IDXW-1:0] arr_set;
      logic [WAYW-1:0] arr_way;
      logic [1:0] cfg_pf;
      logic cfg_gtouch;
      logic last_hit;
      logic priv_fault;
      logic [TAGW-1:0] rd_tag;
      logic rd_vld;
      logic [31:0] rd_data;
      logic [31:0] hits, misses;
      logic pready, pslverr;
      logic [31:0] prdata;
   } ict_regs_t;

   ict_regs_t state_r, state_nxt;

   logic [TAGW-1:0] f_look_tag, o_look_tag;
   logic [IDXW-1:0] f_look_set, o_look_set;
   logic f_hit, o_hit;
   logic [WAYW-1:0] f_hit_way, o_hit_way;
   logic [WAYS-1:0] o_hit_vec;
   logic [11:0] reg_off;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////////
   // address split: set from the real address, tag from the virtual one
   assign f_look_tag = {fetch_effective_addr[`ICT_TAG_HI:`ICT_TAG_LO],
                        process_identifier, instr_addr_space_bit};
   // bits 22:31 are never translated, so the real index equals the ea index
   assign f_look_set = fetch_real_addr[`ICT_IDX_HI:`ICT_IDX_LO];
   // management ops name their space by the data space bit
   assign o_look_tag = {op_effective_addr[`ICT_TAG_HI:`ICT_TAG_LO],
                        process_identifier, data_addr_space_bit};
   assign o_look_set = op_real_addr[`ICT_IDX_HI:`ICT_IDX_LO];

   // parallel compare for the fetch path
   ict_set_match #(.WAYS(WAYS), .TAGW(TAGW), .WAYW(WAYW)) u_fetch_match (
      .set_tags(state_r.tag[f_look_set]),
      .set_valid(state_r.vld[f_look_set]),
      .look_tag(f_look_tag),
      .hit_vec(),
      .hit(f_hit),
      .hit_way(f_hit_way)
   );

   // second compare so ops never steal the fetch port
   ict_set_match #(.WAYS(WAYS), .TAGW(TAGW), .WAYW(WAYW)) u_op_match (
      .set_tags(state_r.tag[o_look_set]),
      .set_valid(state_r.vld[o_look_set]),
      .look_tag(o_look_tag),
      .hit_vec(o_hit_vec),
      .hit(o_hit),
      .hit_way(o_hit_way)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   assign reg_off = paddr[11:0];
   assign mapped = (paddr[31:12] == 20'h00000) &&
                   (reg_off == `ICT_REG_CFG || reg_off == `ICT_REG_STATUS ||
                    reg_off == `ICT_REG_RTAG || reg_off == `ICT_REG_RINFO ||
                    reg_off == `ICT_REG_RDATA || reg_off == `ICT_REG_HITS ||
                    reg_off == `ICT_REG_MISSES);

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic for the whole block
   always_comb begin
      logic [WAYW-1:0] victim;
      logic pfault_set;
      victim = '0;
      pfault_set = 1'b0;
      state_nxt = state_r;
      state_nxt.fill_req = 1'b0;
      state_nxt.fetch_hit = 1'b0;
      state_nxt.fetch_miss = 1'b0;
      state_nxt.op_done = 1'b0;
      state_nxt.op_refused = 1'b0;
      state_nxt.arr_rd_req = 1'b0;

      // apb: answer decoded in setup, write applied at the completing edge
      if (psel && !penable) begin
         state_nxt.pready = 1'b1;
         state_nxt.pslverr = !mapped;
         state_nxt.prdata = 32'h0000_0000;
         if (!pwrite && mapped) begin
            case (reg_off)
               `ICT_REG_CFG: begin
                  state_nxt.prdata[`ICT_CFG_PF_HI:`ICT_CFG_PF_LO] = state_r.cfg_pf;
                  state_nxt.prdata[`ICT_CFG_GTOUCH] = state_r.cfg_gtouch;
               end
               `ICT_REG_STATUS: begin
                  state_nxt.prdata[`ICT_STS_HIT] = state_r.last_hit;
                  state_nxt.prdata[`ICT_STS_BUSY] = (state_r.st != ICT_ST_IDLE);
                  state_nxt.prdata[`ICT_STS_PFAULT] = state_r.priv_fault;
               end
               `ICT_REG_RTAG: state_nxt.prdata = state_r.rd_tag[TAGW-1:TAGW-32];
               `ICT_REG_RINFO: state_nxt.prdata[0] = state_r.rd_vld;
               `ICT_REG_RDATA: state_nxt.prdata = state_r.rd_data;
               `ICT_REG_HITS: state_nxt.prdata = state_r.hits;
               `ICT_REG_MISSES: state_nxt.prdata = state_r.misses;
               default: state_nxt.prdata = 32'h0000_0000;
            endcase
         end
      end else if (psel && penable && state_r.pready) begin
         state_nxt.pready = 1'b0;
         state_nxt.pslverr = 1'b0;
         if (pwrite && mapped) begin
            case (reg_off)
               `ICT_REG_CFG: begin
                  state_nxt.cfg_pf = pwdata[`ICT_CFG_PF_HI:`ICT_CFG_PF_LO];
                  state_nxt.cfg_gtouch = pwdata[`ICT_CFG_GTOUCH];
               end
               `ICT_REG_STATUS: begin
                  // write one to clear; a fault in this cycle is set below
                  if (pwdata[`ICT_STS_PFAULT]) begin
                     state_nxt.priv_fault = 1'b0;
                  end
               end
               default: state_nxt.priv_fault = state_nxt.priv_fault;
            endcase
         end
      end else begin
         state_nxt.pready = 1'b0;
         state_nxt.pslverr = 1'b0;
      end

      // fetch lookup result, one cycle after the request
      if (fetch_req) begin
         state_nxt.fetch_hit = f_hit;
         state_nxt.fetch_miss = !f_hit;
         state_nxt.fetch_set = f_look_set;
         state_nxt.fetch_way = f_hit_way;
         state_nxt.last_hit = f_hit;
         if (f_hit) begin
            state_nxt.hits = state_r.hits + 32'h0000_0001;
         end else begin
            state_nxt.misses = state_r.misses + 32'h0000_0001;
         end
      end

      case (state_r.st)
         ICT_ST_IDLE: begin
            if (op_req) begin
               case (op_code)
                  ICT_OP_INVAL: begin
                     // only the exact virtual line goes; synonyms stay
                     if (o_hit) begin
                        state_nxt.vld[o_look_set] =
                           state_r.vld[o_look_set] & ~o_hit_vec;
                     end
                     // no match: nothing but the done pulse changes
                     state_nxt.op_done = 1'b1;
                  end
                  ICT_OP_TOUCH: begin
                     state_nxt.op_done = 1'b1;
                     if (!o_hit) begin
                        state_nxt.st = ICT_ST_FILL;
                        state_nxt.fill_req = 1'b1;
                        state_nxt.fill_ra = {op_real_addr[31:`ICT_IDX_LO],
                                             {`ICT_IDX_LO{1'b0}}};
                        state_nxt.f_tag = o_look_tag;
                        state_nxt.f_set = o_look_set;
                        state_nxt.f_alloc = op_exec_ok && !op_cache_inhib;
                        state_nxt.f_touch = 1'b1;
                     end
                  end
                  ICT_OP_FLASH: begin
                     if (priv_state) begin
                        state_nxt.vld = '0;
                        state_nxt.op_done = 1'b1;
                     end else begin
                        state_nxt.op_refused = 1'b1;
                        pfault_set = 1'b1;
                     end
                  end
                  ICT_OP_READ: begin
                     if (priv_state) begin
                        state_nxt.rd_tag = state_r.tag[o_look_set][op_way];
                        state_nxt.rd_vld = state_r.vld[o_look_set][op_way];
                        state_nxt.arr_rd_req = 1'b1;
                        state_nxt.arr_set = o_look_set;
                        state_nxt.arr_way = op_way;
                        state_nxt.st = ICT_ST_RDATA;
                     end else begin
                        state_nxt.op_refused = 1'b1;
                        pfault_set = 1'b1;
                     end
                  end
                  default: state_nxt.op_refused = 1'b1;
               endcase
            end else if (fetch_req && !f_hit) begin
               // miss starts a fill; a busy controller lets the core retry
               state_nxt.st = ICT_ST_FILL;
               state_nxt.fill_req = 1'b1;
               state_nxt.fill_ra = {fetch_real_addr[31:`ICT_IDX_LO],
                                    {`ICT_IDX_LO{1'b0}}};
               state_nxt.f_tag = f_look_tag;
               state_nxt.f_set = f_look_set;
               state_nxt.f_alloc = fetch_exec_ok && !fetch_cache_inhib;
               state_nxt.f_touch = 1'b0;
            end
         end
         ICT_ST_FILL: begin
            // a touch is dropped on a stall unless the config guarantees it
            if (state_r.f_touch && !state_r.cfg_gtouch && pipe_stall) begin
               state_nxt.f_alloc = 1'b0;
            end
            if (fill_done) begin
               state_nxt.st = ICT_ST_IDLE;
               // prefer a free way, else round robin; no synonym search
               victim = state_r.rr;
               for (int w = WAYS - 1; w >= 0; w--) begin
                  if (!state_r.vld[state_r.f_set][w]) begin
                     victim = WAYW'(w);
                  end
               end
               if (state_nxt.f_alloc) begin
                  state_nxt.tag[state_r.f_set][victim] = state_r.f_tag;
                  state_nxt.vld[state_r.f_set][victim] = 1'b1;
                  state_nxt.rr = state_r.rr + WAYW'(1);
               end
            end
         end
         ICT_ST_RDATA: begin
            // array answers in the cycle its read strobe is high
            state_nxt.rd_data = arr_rd_data;
            state_nxt.op_done = 1'b1;
            state_nxt.st = ICT_ST_IDLE;
         end
         default: state_nxt.st = ICT_ST_IDLE;
      endcase

      // sticky fault: a new fault beats a clear in the same cycle
      if (pfault_set) begin
         state_nxt.priv_fault = 1'b1;
      end
      state_nxt.op_ready = (state_nxt.st == ICT_ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset clears the struct, tags and valid bits alike, but loads op_ready high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= '0;
         state_r.st <= ICT_ST_IDLE;
         state_r.cfg_pf <= `ICT_CFG_PF_RESET;
         state_r.cfg_gtouch <= `ICT_CFG_GTOUCH_RESET;
         state_r.op_ready <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign prdata = state_r.prdata;
   assign pready = state_r.pready;
   assign pslverr = state_r.pslverr;
   assign fetch_hit = state_r.fetch_hit;
   assign fetch_miss = state_r.fetch_miss;
   assign fetch_set = state_r.fetch_set;
   assign fetch_way = state_r.fetch_way;
   assign op_ready = state_r.op_ready;
   assign op_done = state_r.op_done;
   assign op_refused = state_r.op_refused;
   assign fill_req = state_r.fill_req;
   assign fill_real_addr = state_r.fill_ra;
   // prefetch depth handed to the fill engine
   assign prefetch_lines = state_r.cfg_pf;
   assign arr_rd_req = state_r.arr_rd_req;
   assign arr_rd_set = state_r.arr_set;
   assign arr_rd_way = state_r.arr_way;
endmodule
`default_nettype wire

/* File: include/ict_pkg.sv */
`default_nettype none
package ict_pkg;
   // cache management operations from the decoder
   typedef enum logic [1:0] {
      ICT_OP_INVAL = 2'h0,
      ICT_OP_TOUCH = 2'h1,
      ICT_OP_FLASH = 2'h2,
      ICT_OP_READ = 2'h3
   } ict_op_t;
   // controller states, gray along idle-fill and idle-rdata
   typedef enum logic [1:0] {
      ICT_ST_IDLE = 2'h0,
      ICT_ST_FILL = 2'h1,
      ICT_ST_RDATA = 2'h2
   } ict_state_t;
endpackage
`default_nettype wire

/* File: include/ict_regs.svh */
`ifndef ICT_REGS_SVH
`define ICT_REGS_SVH
// line geometry: bytes per line and doublewords per line
`define ICT_LINE_BYTES 32
`define ICT_LINE_DWORDS 4
// address field positions, little-endian bit numbers
`define ICT_OFF_LO 0
`define ICT_OFF_HI 4
`define ICT_IDX_LO 5
`define ICT_IDX_HI 8
`define ICT_TAG_LO 9
`define ICT_TAG_HI 31
// register byte offsets on the apb bus
`define ICT_REG_CFG 12'h000
`define ICT_REG_STATUS 12'h004
`define ICT_REG_RTAG 12'h008
`define ICT_REG_RINFO 12'h00C
`define ICT_REG_RDATA 12'h010
`define ICT_REG_HITS 12'h014
`define ICT_REG_MISSES 12'h018
// core_config_reg fields
`define ICT_CFG_PF_LO 0
`define ICT_CFG_PF_HI 1
`define ICT_CFG_GTOUCH 2
// status fields
`define ICT_STS_HIT 0
`define ICT_STS_BUSY 1
`define ICT_STS_PFAULT 2
// reset values
`define ICT_CFG_PF_RESET 2'h0
`define ICT_CFG_GTOUCH_RESET 1'h0
`endif

/* File: testbench/ict_fill_model.sv */
`default_nettype none
module ict_fill_model #(
   parameter int DELAY = 4
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic fill_req, // fill start
   output logic fill_done, // fill complete pulse
   input wire logic arr_rd_req, // array read
   input wire logic [3:0] arr_rd_set, // read set
   input wire logic [5:0] arr_rd_way, // read way
   output logic [31:0] arr_rd_data // read word
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_r;
   ////////////////////////////////////////
   // line fill takes a few cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 0;
      end else if (fill_req) begin
         cnt_r <= DELAY;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   // word pattern names set and way, garbage when not read
   assign fill_done = (cnt_r == 1);
   assign arr_rd_data = arr_rd_req ? {16'hA5C3, 6'h0, arr_rd_set, arr_rd_way} : 32'h5A5A_0F0F;
endmodule
`default_nettype wire

/* File: testbench/ict_tag_lookup_checker.sv */
`default_nettype none
module ict_tag_lookup_checker
   import ict_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic priv_state, // privileged
   input wire logic fetch_req, // lookup request
   input wire logic [31:0] fetch_real_addr, // fetch real
   input wire logic fetch_hit, // hit pulse
   input wire logic fetch_miss, // miss pulse
   input wire logic [3:0] fetch_set, // hit set
   input wire logic op_req, // op request
   input wire logic op_ready, // op accept
   input wire ict_op_t op_code, // op kind
   input wire logic [31:0] op_real_addr, // op real
   input wire logic op_done, // op done
   input wire logic op_refused, // op refused
   input wire logic fill_req, // fill start
   input wire logic [31:0] fill_real_addr, // fill address
   input wire logic arr_rd_req, // array read
   input wire logic [3:0] arr_rd_set // array set
);
   timeunit 1ns;
   timeprecision 1ps;
   logic taken;
   ////////////////////////////////////////
   // an op is taken on an edge with request and ready together
   assign taken = op_req && op_ready;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   a_fetch_answer: assert property (fetch_req |=> fetch_hit != fetch_miss)
      else $error("lookup gave no single answer");
   a_no_answer: assert property (!fetch_req |=> !fetch_hit && !fetch_miss)
      else $error("answer without lookup");
   a_hit_set: assert property (fetch_hit |-> fetch_set == $past(fetch_real_addr[8:5]))
      else $error("hit set not from real index");
   a_fill_align: assert property (fill_req |-> fill_real_addr[4:0] == 5'h0)
      else $error("fill not line aligned");
   a_fill_cause: assert property (fill_req |->
      fetch_miss || $past(taken && op_code == ICT_OP_TOUCH))
      else $error("fill without miss or touch");
   a_fill_busy: assert property (fill_req |=> !op_ready)
      else $error("ops accepted during fill");
   a_op_answer: assert property (taken && op_code != ICT_OP_READ |=> op_done != op_refused)
      else $error("op gave no single answer");
   a_flash_priv: assert property (taken && op_code == ICT_OP_FLASH && !priv_state |=>
      op_refused)
      else $error("user flash not refused");
   a_read_seq: assert property (taken && op_code == ICT_OP_READ && priv_state |=>
      arr_rd_req && arr_rd_set == $past(op_real_addr[8:5]) ##1 op_done)
      else $error("cache read sequence wrong");
endmodule
bind ict_tag_lookup ict_tag_lookup_checker u_chk (.pclk, .presetn, .priv_state, .fetch_req,
   .fetch_real_addr, .fetch_hit, .fetch_miss, .fetch_set, .op_req, .op_ready, .op_code,
   .op_real_addr, .op_done, .op_refused, .fill_req, .fill_real_addr, .arr_rd_req, .arr_rd_set);
`default_nettype wire

/* File: testbench/ict_tag_lookup_test.sv */
`include "ict_regs.svh"
`default_nettype none
`define ICT_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ict_tag_lookup_test;
   import ict_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] EA1 = 32'h1234_5660, EA2 = 32'h5670_0660, RA = 32'h0008_9660;
   localparam logic [31:0] EA3 = 32'h2222_2A80, RA3 = 32'h0004_0A80;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [31:0] paddr = '0, pwdata = '0, fetch_effective_addr = '0, fetch_real_addr = '0;
   logic [31:0] op_effective_addr = '0, op_real_addr = '0, prdata, fill_real_addr, arr_rd_data;
   logic [7:0] process_identifier = '0;
   logic instr_addr_space_bit = 1'h0, data_addr_space_bit = 1'h0, priv_state = 1'h0;
   logic fetch_req = 1'h0, fetch_exec_ok = 1'h1, fetch_cache_inhib = 1'h0, op_req = 1'h0;
   logic op_exec_ok = 1'h1, op_cache_inhib = 1'h0, pipe_stall = 1'h0;
   ict_op_t op_code = ICT_OP_INVAL;
   logic [5:0] op_way = '0, fetch_way, arr_rd_way;
   logic [3:0] fetch_set, arr_rd_set;
   logic [1:0] prefetch_lines;
   logic pready, pslverr, fetch_hit, fetch_miss, op_ready, op_done, op_refused;
   logic fill_req, fill_done, arr_rd_req, err;
   logic [31:0] rd;
   int mismatches = 0, cmp_count = 0;
   ////////////////////////////////////////
   ict_tag_lookup u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .process_identifier, .instr_addr_space_bit, .data_addr_space_bit,
      .priv_state, .fetch_req, .fetch_effective_addr, .fetch_real_addr, .fetch_exec_ok,
      .fetch_cache_inhib, .fetch_hit, .fetch_miss, .fetch_set, .fetch_way, .op_req, .op_code,
      .op_effective_addr, .op_real_addr, .op_way, .op_exec_ok, .op_cache_inhib, .op_ready,
      .op_done, .op_refused, .pipe_stall, .fill_req, .fill_real_addr, .fill_done,
      .prefetch_lines, .arr_rd_req, .arr_rd_set, .arr_rd_way, .arr_rd_data);
   ict_fill_model u_fill (.pclk, .presetn, .fill_req, .fill_done, .arr_rd_req, .arr_rd_set,
      .arr_rd_way, .arr_rd_data);
   ////////////////////////////////////////
   // bus and port helpers; all drive right after a rising edge
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic check_reg(input logic [31:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      `ICT_CHK(rd, exp)
   endtask
   // a fill may hold ops off for a while: wait, but not forever
   task automatic wait_ready();
      for (int i = 0; i < 40 && op_ready !== 1'h1; i++) @(posedge pclk);
      `ICT_CHK(op_ready, 1'h1)
   endtask
   task automatic fetch(input logic [31:0] ea, input logic [31:0] ra, input logic exp);
      @(posedge pclk);
      fetch_req <= 1'h1;
      fetch_effective_addr <= ea;
      fetch_real_addr <= ra;
      @(posedge pclk);
      fetch_req <= 1'h0;
      @(posedge pclk);
      `ICT_CHK(fetch_hit, exp)
      `ICT_CHK(fetch_miss, !exp)
      if (exp) `ICT_CHK(fetch_set, ra[8:5])
      if (fill_req === 1'h1) `ICT_CHK(fill_real_addr, {ra[31:5], 5'h0})
      wait_ready();
   endtask
   task automatic do_op(input ict_op_t c, input logic [31:0] ea, input logic [31:0] ra,
         input logic ok);
      wait_ready();
      @(posedge pclk);
      op_req <= 1'h1;
      op_code <= c;
      op_effective_addr <= ea;
      op_real_addr <= ra;
      @(posedge pclk);
      op_req <= 1'h0;
      for (int i = 0; i < 4 && op_done !== 1'h1 && op_refused !== 1'h1; i++) @(posedge pclk);
      `ICT_CHK(op_done, ok)
      `ICT_CHK(op_refused, !ok)
      wait_ready();
   endtask
   ////////////////////////////////////////
   // scenarios
   task automatic t_regs();
      check_reg(32'(`ICT_REG_CFG), 32'h0);
      apb(1'h1, 32'(`ICT_REG_CFG), 32'h6);
      check_reg(32'(`ICT_REG_CFG), 32'h6);
      `ICT_CHK(prefetch_lines, 2'h2)
      apb(1'h0, 32'h0000_0100, 32'h0);
      `ICT_CHK(err, 1'h1)
   endtask
   task automatic t_fetch();
      process_identifier <= 8'h3C;
      instr_addr_space_bit <= 1'h1;
      fetch(EA1, RA, 1'h0);
      fetch(EA1, RA, 1'h1);
      process_identifier <= 8'h3D;
      fetch(EA1, RA, 1'h0);
      process_identifier <= 8'h3C;
      fetch_exec_ok <= 1'h0;
      fetch(EA2, RA, 1'h0);
      fetch_exec_ok <= 1'h1;
      fetch_cache_inhib <= 1'h1;
      fetch(EA2, RA, 1'h0);
      fetch_cache_inhib <= 1'h0;
      fetch(EA2, RA, 1'h0);
      fetch(EA2, RA, 1'h1);
      fetch(EA1, RA, 1'h1);
   endtask
   // fetch space low while data space high: removal proves the data bit tags the op
   task automatic t_inval();
      instr_addr_space_bit <= 1'h0;
      data_addr_space_bit <= 1'h1;
      do_op(ICT_OP_INVAL, EA1, RA, 1'h1);
      instr_addr_space_bit <= 1'h1;
      fetch(EA2, RA, 1'h1);
      fetch(EA1, RA, 1'h0);
      do_op(ICT_OP_INVAL, 32'h7777_7660, RA, 1'h1);
      fetch(EA1, RA, 1'h1);
      do_op(ICT_OP_INVAL, EA2, RA, 1'h1);
      fetch(EA2, RA, 1'h0);
   endtask
   task automatic t_flash_read();
      do_op(ICT_OP_FLASH, 32'h0, 32'h0, 1'h0);
      check_reg(32'(`ICT_REG_STATUS), 32'h4);
      fetch(EA1, RA, 1'h1);
      priv_state <= 1'h1;
      do_op(ICT_OP_FLASH, 32'h0, 32'h0, 1'h1);
      fetch(EA1, RA, 1'h0);
      do_op(ICT_OP_READ, EA1, RA, 1'h1);
      check_reg(32'(`ICT_REG_RTAG), {EA1[31:9], 8'h3C, 1'h1});
      check_reg(32'(`ICT_REG_RINFO), 32'h1);
      check_reg(32'(`ICT_REG_RDATA), {16'hA5C3, 6'h0, RA[8:5], 6'h0});
      priv_state <= 1'h0;
      do_op(ICT_OP_READ, EA1, RA, 1'h0);
   endtask
   task automatic t_touch();
      pipe_stall <= 1'h1;
      do_op(ICT_OP_TOUCH, EA3, RA3, 1'h1);
      fetch(EA3, RA3, 1'h1);
      fetch(EA3 + 32'h20, RA3 + 32'h20, 1'h0);
      apb(1'h1, 32'(`ICT_REG_CFG), 32'h0);
      do_op(ICT_OP_TOUCH, EA2, RA, 1'h1);
      fetch(EA2, RA, 1'h0);
   endtask
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // clock, then the sequence after ten cycles of reset
   initial forever #10 pclk = ~pclk;
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_fetch();
      t_inval();
      t_flash_read();
      t_touch();
      give_verdict();
   end
   // the sequence needs well under a thousand cycles; ten thousand means a hang
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
